// [verilog/mid_pkg.sv]
// Purpose: Shared constants for the instruction decode core.
// Assumes: 13-bit instruction words, 8-bit data path.
// Notes: Option words are held outside and arrive as plain inputs.
package mid_pkg;
	// ==============================================================
	// Widths and timing
	localparam int INSTR_W = 13;
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 8;
	localparam logic [2:0] OSC_PER_CYCLE_FAST = 3'h2;
	localparam logic [2:0] OSC_PER_CYCLE_SLOW = 3'h4;
	// ==============================================================
	// Option word bit positions
	localparam int OPT0_PERIOD_BIT = 8;
	localparam int OPT1_CYCLE_BIT = 6;
	// ==============================================================
	// Register indices
	localparam logic [5:0] REG_PC = 6'h02;
	localparam logic [5:0] REG_STATUS = 6'h03;
	localparam logic [5:0] REG_PORT5 = 6'h05;
	localparam logic [5:0] REG_INT_FLAG = 6'h0f;
	// ==============================================================
	// Status register layout and reset
	localparam int STAT_C = 0;
	localparam int STAT_DC = 1;
	localparam int STAT_Z = 2;
	localparam int STAT_P = 3;
	localparam int STAT_T = 4;
	localparam int STAT_PAGE = 5;
	localparam int STAT_BANK = 7;
	localparam logic [7:0] STATUS_RST = 8'h18;
	// ==============================================================
	// Control register bank ranges
	localparam logic [3:0] IOC_FIRST = 4'h5;
	localparam logic [3:0] IOC_LAST_B0 = 4'hf;
	localparam logic [3:0] IOC_LAST_B1 = 4'hc;
	// ==============================================================
	// Fixed opcodes
	localparam logic [12:0] OP_DAA = 13'h0001;
	localparam logic [12:0] OP_CONT_WR = 13'h0002;
	localparam logic [12:0] OP_SLEEP = 13'h0003;
	localparam logic [12:0] OP_WDT_CLEAR = 13'h0004;
	localparam logic [12:0] OP_INT_ENABLE = 13'h0010;
	localparam logic [12:0] OP_INT_DISABLE = 13'h0011;
	localparam logic [12:0] OP_RETURN = 13'h0012;
	localparam logic [12:0] OP_RETURN_INT = 13'h0013;
	localparam logic [12:0] OP_CONT_RD = 13'h0014;
endpackage : mid_pkg

// [verilog/mid_stack.sv]
// Purpose: Hardware return stack for the decode core.
// Assumes: Push and pop never in the same cycle.
// Notes: Overflow wraps and overwrites the oldest entry.
`timescale 1ns/1ns
module mid_stack #(
	parameter int DEPTH = mid_pkg::STACK_DEPTH,
	parameter int W = mid_pkg::PC_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic push,
	input wire logic pop,
	input wire logic [W-1:0] push_data,
	output logic [W-1:0] top
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [PW-1:0] sp_reg;
	logic [PW-1:0] sp_prev;

	// ==============================================================
	// Pointer and storage
	assign sp_prev = sp_reg - 1'b1;
	assign top = mem_reg[sp_prev];

	// Stack pointer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sp_reg <= '0;
		end else if (push) begin
			sp_reg <= sp_reg + 1'b1;
		end else if (pop) begin
			sp_reg <= sp_prev;
		end
	end

	// Entry write on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[sp_reg] <= push_data;
		end
	end
endmodule : mid_stack

// [verilog/mid_core.sv]
// Purpose: Instruction decode and execute timing of an 8-bit core.
// Assumes: Program memory answers pc_out within the same clock.
// Notes: clk is the oscillator; one instruction is 2 or 4 of it.
`timescale 1ns/1ns
module mid_core #(
	parameter int PC_W = mid_pkg::PC_W,
	parameter int STACK_DEPTH = mid_pkg::STACK_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [12:0] instr,
	input wire logic [12:0] option_word0,
	input wire logic [12:0] option_word1,
	input wire logic wake,
	output logic [PC_W-1:0] pc_out,
	output logic instr_taken,
	output logic [7:0] acc_out,
	output logic [7:0] status_out,
	output logic [7:0] port5_out,
	output logic int_enable,
	output logic watchdog_clear,
	output logic osc_stop
);
	// ==============================================================
	// Functions
	// Add or subtract x - y, returns {dc, c, result}
	function automatic logic [9:0] mid_addsub(input logic [7:0] x,
		input logic [7:0] y, input logic sub);
		logic [7:0] yy;
		logic [4:0] lo;
		logic [8:0] full;
		yy = sub ? ~y : y;
		lo = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, sub};
		full = {1'b0, x} + {1'b0, yy} + {8'h00, sub};
		return {lo[4], full[8], full[7:0]};
	endfunction : mid_addsub

	// Control register index valid for the selected bank
	function automatic logic mid_ioc_ok(input logic bank,
		input logic [3:0] idx);
		return idx >= mid_pkg::IOC_FIRST && idx <= (bank ?
			mid_pkg::IOC_LAST_B1 : mid_pkg::IOC_LAST_B0);
	endfunction : mid_ioc_ok

	// ==============================================================
	// State
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [7:0] acc_reg;
	logic [7:0] cont_reg;
	logic [7:0] regs_reg [64];
	logic [7:0] ioc_reg [2][16];
	logic c_reg, dc_reg, z_reg, t_reg, p_reg;
	logic [1:0] page_reg;
	logic bank_reg;
	logic [2:0] phase_reg;
	logic stall_reg;
	logic skip_reg;
	logic asleep_reg;
	logic ie_reg;
	logic wdt_clr_reg;

	// Decode fields
	logic [5:0] r_idx;
	logic [2:0] bit_sel;
	logic [7:0] k8;
	logic [9:0] k10;
	logic [3:0] sub_op;
	logic dest_r;
	logic [7:0] rv;
	logic [7:0] status_val;
	logic [2:0] last_phase;
	logic exec;

	// Decode results
	logic [7:0] res;
	logic wr_acc, wr_reg, use_dest;
	logic upd_z, upd_c, upd_dc;
	logic c_new, dc_new;
	logic skip_new;
	logic do_push, do_pop, pc_load;
	logic [PC_W-1:0] pc_target;
	logic [PC_W-1:0] pc_target_pop;
	logic cont_wr, ioc_wr, op_sleep, op_wdt, ie_set, ie_clr;
	logic [9:0] as;
	logic [7:0] daa;

	// ==============================================================
	// Field extraction and operand fetch
	assign r_idx = instr[5:0];
	assign bit_sel = instr[8:6];
	assign k8 = instr[7:0];
	assign k10 = instr[9:0];
	assign sub_op = instr[9:6];
	assign dest_r = instr[6];
	assign status_val = {bank_reg, page_reg, t_reg, p_reg, z_reg,
		dc_reg, c_reg};

	// Port and general registers share one read path
	always_comb begin
		unique case (r_idx)
			mid_pkg::REG_PC: rv = pc_reg[7:0];
			mid_pkg::REG_STATUS: rv = status_val;
			default: rv = regs_reg[r_idx];
		endcase
	end

	// Decimal adjust of the accumulator
	always_comb begin
		daa = acc_reg;
		if (dc_reg || acc_reg[3:0] > 4'h9) begin
			daa = daa + 8'h06;
		end
		if (c_reg || acc_reg > 8'h99) begin
			daa = daa + 8'h60;
		end
	end

	// ==============================================================
	// Instruction cycle timing
	assign last_phase = option_word0[mid_pkg::OPT0_PERIOD_BIT] ?
		mid_pkg::OSC_PER_CYCLE_SLOW - 3'h1 :
		mid_pkg::OSC_PER_CYCLE_FAST - 3'h1;
	assign exec = !asleep_reg && !stall_reg &&
		phase_reg == last_phase;
	assign instr_taken = exec;

	// Oscillator period counter within one instruction cycle
	always_ff @(posedge clk) begin
		if (!resetn || asleep_reg || phase_reg >= last_phase) begin
			phase_reg <= 3'h0;
		end else begin
			phase_reg <= phase_reg + 3'h1;
		end
	end

	// Extra cycle after a program counter register write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stall_reg <= 1'b0;
		end else if (exec && wr_reg && r_idx == mid_pkg::REG_PC) begin
			stall_reg <= option_word1[mid_pkg::OPT1_CYCLE_BIT];
		end else if (phase_reg == last_phase) begin
			stall_reg <= 1'b0;
		end
	end

	// ==============================================================
	// Decode of the whole 13-bit word
	always_comb begin
		as = mid_addsub(rv, acc_reg, 1'b0);
		res = rv;
		wr_acc = 1'b0;
		wr_reg = 1'b0;
		use_dest = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		c_new = c_reg;
		dc_new = dc_reg;
		skip_new = 1'b0;
		do_push = 1'b0;
		do_pop = 1'b0;
		pc_load = 1'b0;
		pc_target = {page_reg, k10};
		cont_wr = 1'b0;
		ioc_wr = 1'b0;
		op_sleep = 1'b0;
		op_wdt = 1'b0;
		ie_set = 1'b0;
		ie_clr = 1'b0;
		if (!skip_reg && !instr[12] && instr[11:10] == 2'b00) begin
			use_dest = sub_op >= 4'h4;
			upd_z = sub_op >= 4'h2;
			unique case (sub_op)
				4'h0: begin
					use_dest = 1'b0;
					upd_z = 1'b0;
					if (instr == mid_pkg::OP_DAA) begin
						res = daa;
						wr_acc = 1'b1;
						upd_c = 1'b1;
						c_new = c_reg || acc_reg > 8'h99;
					end else if (instr == mid_pkg::OP_CONT_WR) begin
						cont_wr = 1'b1;
					end else if (instr == mid_pkg::OP_SLEEP) begin
						op_sleep = 1'b1;
					end else if (instr == mid_pkg::OP_WDT_CLEAR) begin
						op_wdt = 1'b1;
					end else if (instr == mid_pkg::OP_INT_ENABLE) begin
						ie_set = 1'b1;
					end else if (instr == mid_pkg::OP_INT_DISABLE) begin
						ie_clr = 1'b1;
					end else if (instr == mid_pkg::OP_RETURN) begin
						do_pop = 1'b1;
					end else if (instr == mid_pkg::OP_RETURN_INT) begin
						do_pop = 1'b1;
						ie_set = 1'b1;
					end else if (instr == mid_pkg::OP_CONT_RD) begin
						res = cont_reg;
						wr_acc = 1'b1;
					end else if (instr[5:4] == 2'b00) begin
						ioc_wr = mid_ioc_ok(bank_reg, instr[3:0]);
					end else if (instr[5:4] == 2'b01) begin
						res = mid_ioc_ok(bank_reg, instr[3:0]) ?
							ioc_reg[bank_reg][instr[3:0]] : 8'h00;
						wr_acc = 1'b1;
					end
				end
				4'h1: begin
					res = acc_reg;
					wr_reg = 1'b1;
				end
				4'h2, 4'h3: begin
					res = 8'h00;
					wr_acc = !dest_r;
					wr_reg = dest_r;
				end
				4'h4, 4'h5, 4'he, 4'hf: begin
					as = mid_addsub(rv, acc_reg, !sub_op[3]);
					res = as[7:0];
					upd_c = 1'b1;
					upd_dc = 1'b1;
					c_new = as[8];
					dc_new = as[9];
				end
				4'h6, 4'h7: res = rv - 8'h01;
				4'h8, 4'h9: res = rv | acc_reg;
				4'ha, 4'hb: res = rv & acc_reg;
				default: res = rv ^ acc_reg;
			endcase
		end else if (!skip_reg && !instr[12] && instr[11:10] == 2'b01) begin
			use_dest = 1'b1;
			upd_z = sub_op <= 4'h5;
			unique case (sub_op)
				4'h0, 4'h1: res = rv;
				4'h2, 4'h3: res = ~rv;
				4'h4, 4'h5: res = rv + 8'h01;
				4'h6, 4'h7: begin
					res = rv - 8'h01;
					skip_new = res == 8'h00;
				end
				4'h8, 4'h9: begin
					res = {c_reg, rv[7:1]};
					c_new = rv[0];
					upd_c = 1'b1;
				end
				4'ha, 4'hb: begin
					res = {rv[6:0], c_reg};
					c_new = rv[7];
					upd_c = 1'b1;
				end
				4'hc, 4'hd: res = {rv[3:0], rv[7:4]};
				default: begin
					res = rv + 8'h01;
					skip_new = res == 8'h00;
				end
			endcase
		end else if (!skip_reg && !instr[12] && !instr[10]) begin
			res = rv;
			res[bit_sel] = instr[9];
			wr_reg = 1'b1;
		end else if (!skip_reg && !instr[12]) begin
			skip_new = rv[bit_sel] == instr[9];
		end else if (!skip_reg && !instr[11]) begin
			pc_load = 1'b1;
			do_push = !instr[10];
		end else if (!skip_reg) begin
			as = mid_addsub(k8, acc_reg, !instr[9]); // Bit 9 low subtracts
			wr_acc = 1'b1;
			upd_z = instr[9:8] != 2'b00;
			unique case (instr[10:8])
				3'h0: res = k8;
				3'h1: res = acc_reg | k8;
				3'h2: res = acc_reg & k8;
				3'h3: res = acc_reg ^ k8;
				3'h4: begin
					res = k8;
					do_pop = 1'b1;
				end
				3'h6: begin
					res = acc_reg;
					wr_acc = 1'b0;
					upd_z = 1'b0;
				end
				default: begin
					res = as[7:0];
					upd_c = 1'b1;
					upd_dc = 1'b1;
					c_new = as[8];
					dc_new = as[9];
				end
			endcase
		end
		if (use_dest) begin
			wr_acc = !dest_r;
			wr_reg = dest_r;
		end
	end

	// ==============================================================
	// Return stack
	mid_stack #(
		.DEPTH(STACK_DEPTH),
		.W(PC_W)
	) u_stack (
		.clk(clk),
		.resetn(resetn),
		.push(exec && do_push),
		.pop(exec && do_pop),
		.push_data(pc_reg + 1'b1),
		.top(pc_target_pop)
	);

	// ==============================================================
	// Program counter
	always_comb begin
		if (do_pop) begin
			pc_next = pc_target_pop;
		end else if (pc_load) begin
			pc_next = pc_target;
		end else if (wr_reg && r_idx == mid_pkg::REG_PC) begin
			pc_next = {pc_reg[PC_W-1:8], res};
		end else begin
			pc_next = pc_reg + 1'b1;
		end
	end

	// Program counter update once per executed instruction
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pc_reg <= '0;
		end else if (exec) begin
			pc_reg <= pc_next;
		end
	end

	// Skip turns the following instruction into a no-op
	always_ff @(posedge clk) begin
		if (!resetn) begin
			skip_reg <= 1'b0;
		end else if (exec) begin
			skip_reg <= skip_new;
		end
	end

	// ==============================================================
	// Accumulator and control registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_reg <= 8'h00;
		end else if (exec && wr_acc) begin
			acc_reg <= res;
		end
	end

	// CONT register, loaded from the accumulator
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cont_reg <= 8'h00;
		end else if (exec && cont_wr) begin
			cont_reg <= acc_reg;
		end
	end

	// Banked control registers
	always_ff @(posedge clk) begin
		if (exec && ioc_wr) begin
			ioc_reg[bank_reg][instr[3:0]] <= acc_reg;
		end
	end

	// General and port registers
	always_ff @(posedge clk) begin
		if (exec && wr_reg && r_idx != mid_pkg::REG_PC &&
			r_idx != mid_pkg::REG_STATUS) begin
			regs_reg[r_idx] <= res;
		end
	end

	// ==============================================================
	// Status flags: ALU updates override a direct write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			{bank_reg, page_reg} <= mid_pkg::STATUS_RST[7:5];
			z_reg <= mid_pkg::STATUS_RST[mid_pkg::STAT_Z];
			dc_reg <= mid_pkg::STATUS_RST[mid_pkg::STAT_DC];
			c_reg <= mid_pkg::STATUS_RST[mid_pkg::STAT_C];
		end else if (exec) begin
			if (wr_reg && r_idx == mid_pkg::REG_STATUS) begin
				bank_reg <= res[mid_pkg::STAT_BANK];
				page_reg <= res[mid_pkg::STAT_PAGE +: 2];
				z_reg <= res[mid_pkg::STAT_Z];
				dc_reg <= res[mid_pkg::STAT_DC];
				c_reg <= res[mid_pkg::STAT_C];
			end
			if (upd_z) begin
				z_reg <= res == 8'h00;
			end
			if (upd_c) begin
				c_reg <= c_new;
			end
			if (upd_dc) begin
				dc_reg <= dc_new;
			end
		end
	end

	// Time-out and power-down flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			t_reg <= mid_pkg::STATUS_RST[mid_pkg::STAT_T];
			p_reg <= mid_pkg::STATUS_RST[mid_pkg::STAT_P];
		end else if (exec && (op_sleep || op_wdt)) begin
			t_reg <= 1'b1;
			p_reg <= op_wdt;
		end
	end

	// ==============================================================
	// Sleep, watchdog clear and interrupt enable
	always_ff @(posedge clk) begin
		if (!resetn) begin
			asleep_reg <= 1'b0;
		end else if (exec && op_sleep) begin
			asleep_reg <= 1'b1;
		end else if (wake) begin
			asleep_reg <= 1'b0;
		end
	end

	// Watchdog clear pulse
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wdt_clr_reg <= 1'b0;
		end else begin
			wdt_clr_reg <= exec && (op_sleep || op_wdt);
		end
	end

	// Interrupt enable
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ie_reg <= 1'b0;
		end else if (exec && ie_set) begin
			ie_reg <= 1'b1;
		end else if (exec && ie_clr) begin
			ie_reg <= 1'b0;
		end
	end

	// ==============================================================
	// Outputs
	assign pc_out = pc_reg;
	assign acc_out = acc_reg;
	assign status_out = status_val;
	assign port5_out = regs_reg[mid_pkg::REG_PORT5];
	assign int_enable = ie_reg;
	assign watchdog_clear = wdt_clr_reg;
	assign osc_stop = asleep_reg;
endmodule : mid_core

// [bench/mid_chk.sv]
// Purpose: Port-level assertions for the instruction decode core.
// Assumes: Option words only change while reset is held.
// Notes: Results are checked only where no skip can be pending.
`timescale 1ns/1ns
module mid_chk #(
	parameter int PC_W = mid_pkg::PC_W,
	parameter int STACK_DEPTH = mid_pkg::STACK_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [12:0] instr,
	input wire logic [12:0] option_word0,
	input wire logic [12:0] option_word1,
	input wire logic wake,
	input wire logic [PC_W-1:0] pc_out,
	input wire logic instr_taken,
	input wire logic [7:0] acc_out,
	input wire logic [7:0] status_out,
	input wire logic [7:0] port5_out,
	input wire logic int_enable,
	input wire logic watchdog_clear,
	input wire logic osc_stop
);
	// ============================================================
	// Helper logic
	logic skip_reg;
	logic act;
	logic lit;
	logic [8:0] res;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Flags an instruction that a skip op may cancel
	always_ff @(posedge clk) begin
		if (!resetn)
			skip_reg <= 1'b0;
		else if (instr_taken)
			skip_reg <= (instr[12:10] == 3'h3) || (instr[12:7] == 6'h0b)
				|| (instr[12:7] == 6'h0f);
	end
	// Executed, literal form
	assign act = instr_taken && !skip_reg;
	assign lit = instr[12:11] == 2'h3;
	// Literal result, bit 8 holds carry or borrow
	always_comb begin
		case (instr[10:8])
			3'h1: res = {1'b0, acc_out | instr[7:0]};
			3'h2: res = {1'b0, acc_out & instr[7:0]};
			3'h3: res = {1'b0, acc_out ^ instr[7:0]};
			3'h5: res = {1'b0, instr[7:0]} - {1'b0, acc_out};
			default: res = {1'b0, instr[7:0]} + {1'b0, acc_out};
		endcase
	end
	// ============================================================
	// Assertions
	lit_pc_a: assert property (instr_taken && lit && instr[10:8] != 3'h4
		|=> pc_out == $past(pc_out) + 1'b1) else $error("pc not advanced");
	lit_logic_a: assert property (act && lit && instr[10:9] != 2'h0
		&& instr[10] == 1'b0 |=> acc_out == $past(res[7:0])
		&& status_out[2] == ($past(res[7:0]) == 8'h00)
		&& status_out[1:0] == $past(status_out[1:0]))
		else $error("logic literal wrong");
	lit_add_a: assert property (act && instr[12:8] == 5'h1f
		|=> acc_out == $past(res[7:0]) && status_out[0] == $past(res[8])
		&& status_out[1] == ($past({1'b0, instr[3:0]}
		+ {1'b0, acc_out[3:0]}) > 5'h0f)) else $error("add literal wrong");
	lit_sub_a: assert property (act && instr[12:8] == 5'h1d
		|=> acc_out == $past(res[7:0]) && status_out[0] == !$past(res[8])
		&& status_out[1] == $past(instr[3:0] >= acc_out[3:0]))
		else $error("sub literal wrong");
	branch_target_a: assert property (act && instr[12:11] == 2'h2
		|=> pc_out == {$past(status_out[6:5]), $past(instr[9:0])})
		else $error("branch target wrong");
	sleep_entry_a: assert property (act && instr == mid_pkg::OP_SLEEP
		|=> osc_stop && status_out[4:3] == 2'h2 && watchdog_clear)
		else $error("sleep entry wrong");
	wdt_clear_a: assert property (act && instr == mid_pkg::OP_WDT_CLEAR
		|=> !osc_stop && status_out[4:3] == 2'h3 && watchdog_clear)
		else $error("watchdog clear wrong");
	clear_pulse_a: assert property ($rose(watchdog_clear)
		|=> !watchdog_clear) else $error("clear pulse too long");
	sleep_hold_a: assert property (osc_stop |-> !instr_taken)
		else $error("executed while asleep");
	return_from_interrupt_op_enable_a: assert property (act && instr == mid_pkg::OP_RETURN_INT
		|=> int_enable) else $error("interrupts not enabled");
	period_fast_a: assert property (instr_taken && lit && !option_word0[8]
		|=> !instr_taken ##1 instr_taken) else $error("fast period wrong");
	period_slow_a: assert property (instr_taken && lit && option_word0[8]
		|=> !instr_taken [*3] ##1 instr_taken) else $error("slow period wrong");
	pc_stall_a: assert property (act && instr == 13'h0042
		&& option_word1[6] && !option_word0[8]
		|=> pc_out[7:0] == $past(acc_out) && !instr_taken ##1 !instr_taken [*2]
		##1 instr_taken) else $error("pc write stall wrong");
	pc_nostall_a: assert property (act && instr == 13'h0042
		&& !option_word1[6] && option_word0[8]
		|=> !instr_taken [*3] ##1 instr_taken) else $error("pc write stalled");
endmodule : mid_chk

bind mid_core mid_chk #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) mid_chk_i (
	.clk(clk), .resetn(resetn), .instr(instr), .option_word0(option_word0),
	.option_word1(option_word1), .wake(wake), .pc_out(pc_out),
	.instr_taken(instr_taken), .acc_out(acc_out), .status_out(status_out),
	.port5_out(port5_out), .int_enable(int_enable),
	.watchdog_clear(watchdog_clear), .osc_stop(osc_stop));

// [bench/mid_tb.sv]
// Purpose: Self-checking bench for the instruction decode core.
// Assumes: Page bits stay zero, so branch targets fit in ten bits.
// Notes: A behavioural model steps each instruction and is compared.
`timescale 1ns/1ns
module tb;
	// ============================================================
	// Signals and model state
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [12:0] instr = 13'h0000;
	logic [12:0] option_word0 = 13'h1fff;
	logic [12:0] option_word1 = 13'h1fff;
	logic wake = 1'b0;
	logic [11:0] pc_out;
	logic instr_taken;
	logic [7:0] acc_out;
	logic [7:0] status_out;
	logic [7:0] port5_out;
	logic int_enable;
	logic watchdog_clear;
	logic osc_stop;
	int num_errors = 0;
	int n_checks = 0;
	int a, c, dc, z, t, p, bk, pc, ie, cn, sk, per, xt, nc, pv;
	int r[64];
	int io[32];
	int stk[$];
	int lm[8] = '{0, 4, 5, 6, 0, 2, 0, 7};
	int lf[6] = '{0, 1, 2, 3, 5, 7};
	int dir[] = '{'h1840, 'h0042, 'h1841, 'h0042, 'h1801, 'h0050, 'h05d0,
		'h18aa, 'h18ff, 'h0051, 'h07d1, 'h1855, 'h1020, 'h1c33, 'h1050,
		'h1477, 'h0012, 'h1060, 'h0011, 'h0013, 'h0011, 'h0010, 'h18a5,
		'h0007, 'h1800, 'h0017, 'h0bc3, 'h185a, 'h000d, 'h001d, 'h09c3,
		'h1866, 'h0001, 'h0002, 'h1800, 'h0014};
	// Clock and device
	always #50 clk = ~clk;
	mid_core mid_core_i (.clk(clk), .resetn(resetn), .instr(instr),
		.option_word0(option_word0), .option_word1(option_word1),
		.wake(wake), .pc_out(pc_out), .instr_taken(instr_taken),
		.acc_out(acc_out), .status_out(status_out), .port5_out(port5_out),
		.int_enable(int_enable), .watchdog_clear(watchdog_clear),
		.osc_stop(osc_stop));
	// ============================================================
	// Model
	task automatic cmp(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	function automatic int st();
		return bk * 128 + t * 16 + p * 8 + z * 4 + dc * 2 + c;
	endfunction : st
	function automatic int rd(input int i);
		return (i == 3) ? st() : r[i];
	endfunction : rd
	task automatic wr(input int i, input int v);
		if (i == 2) begin
			pc = v;
			xt = option_word1[6];
		end else if (i == 3) begin
			bk = v >> 7 & 1;
			z = v >> 2 & 1;
			dc = v >> 1 & 1;
			c = v & 1;
		end else
			r[i] = v;
		if (i == 5)
			pv = 1;
	endtask : wr
	task automatic alu(input int g, input int x, output int v);
		case (g)
			0: v = a;
			1: v = 0;
			2: v = x - a;
			3, 11: v = x - 1;
			4: v = x | a;
			5: v = x & a;
			6: v = x ^ a;
			7: v = x + a;
			9: v = ~x;
			10, 15: v = x + 1;
			12: v = (x >> 1) | (c << 7);
			13: v = (x << 1) | c;
			14: v = (x >> 4) | (x << 4);
			default: v = x;
		endcase
		if (g == 2) begin
			c = x >= a;
			dc = (x & 15) >= (a & 15);
		end
		if (g == 7) begin
			c = v > 255;
			dc = (x & 15) + (a & 15) > 15;
		end
		if (g == 12)
			c = x & 1;
		if (g == 13)
			c = x >> 7 & 1;
		v = v & 255;
		if (g > 0 && g < 11)
			z = v == 0;
		if ((g == 11 || g == 15) && v == 0)
			sk = 1;
	endtask : alu
	task automatic step(input int op);
		int f, i, v, b;
		f = op >> 6 & 31;
		i = op & 63;
		pc = (pc + 1) & 4095;
		xt = 0;
		if (sk) begin
			sk = 0;
			return;
		end
		if (op >= 'h1800) begin
			if ((op >> 8 & 7) == 4)
				pc = stk.pop_front();
			if ((op >> 8 & 7) == 0 || (op >> 8 & 7) == 4)
				a = op & 255;
			else if ((op >> 8 & 7) != 6) begin
				alu(lm[op >> 8 & 7], op & 255, v);
				a = v;
			end
		end else if (op >= 'h1000) begin
			if ((op & 'h400) == 0)
				stk.push_front(pc);
			pc = op & 1023;
		end else if (op >= 'h800) begin
			b = op >> 6 & 7;
			v = rd(i);
			case (op >> 9 & 3)
				0: wr(i, v & ~(1 << b));
				1: wr(i, v | 1 << b);
				2: sk = (v >> b & 1) == 0;
				default: sk = v >> b & 1;
			endcase
		end else if (f > 0) begin
			alu(f >> 1, rd(i), v);
			if (f & 1)
				wr(i, v);
			else
				a = v;
		end else begin
			// Decimal adjust, carry only
			if (op == 1) begin
				v = a + ((dc || (a & 15) > 9) ? 6 : 0);
				if (c || a > 'h99)
					v += 'h60;
				c = c || a > 'h99;
				a = v & 255;
			end
			if (op == 2)
				cn = a;
			if (op == 'h14)
				a = cn;
			if (op == 3 || op == 4) begin
				t = 1;
				p = op == 4;
			end
			if (op == 'h10 || op == 'h13)
				ie = 1;
			if (op == 'h11)
				ie = 0;
			if (op == 'h12 || op == 'h13)
				pc = stk.pop_front();
			if (op > 4 && op < 16 && (bk == 0 || op < 13))
				io[bk * 16 + op] = a;
			if (op > 'h14 && op < 'h20)
				a = (bk == 0 || i < 'h1d) ? io[bk * 16 + (i & 15)] : 0;
		end
	endtask : step
	// ============================================================
	// Drivers
	task automatic run(input int op);
		int n;
		n = 0;
		instr = op;
		while (instr_taken !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (!nc)
			cmp("gap", per * (1 + xt) - 1, n);
		nc = 0;
		step(op);
		@(negedge clk);
		cmp("pc", pc, pc_out);
		cmp("acc", a, acc_out);
		cmp("status", st(), status_out);
		cmp("int_enable", ie, int_enable);
		if (pv)
			cmp("port5", r[5], port5_out);
	endtask : run
	task automatic rst(input logic o0, input logic o1);
		@(negedge clk);
		resetn = 1'b0;
		option_word0[8] = o0;
		option_word1[6] = o1;
		repeat (6) @(negedge clk);
		cmp("pc", 0, pc_out);
		cmp("status", 'h18, status_out);
		cmp("sleep", 0, osc_stop);
		resetn = 1'b1;
		{a, c, dc, z, bk, pc, ie, sk, xt, nc} = '0;
		t = 1;
		p = 1;
		stk.delete();
		per = o0 ? 4 : 2;
	endtask : rst
	function automatic int rnd();
		int q;
		q = $urandom % 17;
		q = (q == 16) ? 5 : q + 16;
		case ($urandom % 3)
			0: return 'h1800 | lf[$urandom % 6] << 8 | ($urandom & 255);
			1: return (1 + $urandom % 31) << 6 | q;
			default: return 'h800 | ($urandom & 63) << 6 | q;
		endcase
	endfunction : rnd
	task automatic prog();
		run('h1800);
		run('h0045);
		for (int i = 16; i < 32; i++) begin
			run('h1800 | ($urandom & 255));
			run('h40 | i);
		end
		foreach (dir[j])
			run(dir[j]);
		$display("test directed done");
		for (int j = 0; j < 60; j++)
			run(rnd());
		$display("test random done");
		run('h0004);
		cmp("watchdog_clear", 1, watchdog_clear);
		run('h0003);
		cmp("watchdog_clear", 1, watchdog_clear);
		repeat (6) @(negedge clk);
		cmp("osc_stop", 1, osc_stop);
		cmp("watchdog_clear", 0, watchdog_clear);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		nc = 1;
		run('h1812);
		cmp("osc_stop", 0, osc_stop);
		$display("test sleep done");
	endtask : prog
	// ============================================================
	// Sequence, watchdog and verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		void'($urandom(32'h2714));
		rst(1'b0, 1'b1);
		prog();
		rst(1'b1, 1'b0);
		prog();
		complete_run();
	end
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
endmodule : tb
